// [shared/hmu_regs.vh]
// Purpose: constants for the halfword multiply unit
// Assumes: big-endian bit numbering maps bit 0 to verilog bit 31
// Notes:   definitions only
`ifndef HMU_REGS_VH
`define HMU_REGS_VH

// =====================================================================
// halfword selection
`define HMU_HI_MSB        31
`define HMU_HI_LSB        16
`define HMU_LO_MSB        15
`define HMU_LO_LSB        0

// =====================================================================
// condition field bit positions (verilog index within 4-bit field)
`define HMU_CF_LT         3
`define HMU_CF_GT         2
`define HMU_CF_EQ         1
`define HMU_CF_SO         0
`define HMU_CF_RESET      4'h0

// =====================================================================
// exception register summary-overflow bit (architectural bit 0)
`define HMU_XER_SO        31

// =====================================================================
// program interrupt vector
`define HMU_VEC_PROGRAM   32'h0000_0700

// =====================================================================
// primary opcodes of floating-point instructions
`define HMU_OPC_FP_A      6'h3b
`define HMU_OPC_FP_B      6'h3f
`define HMU_OPC_FP_LDMIN  6'h30
`define HMU_OPC_FP_LDMAX  6'h37

`endif

// [rtl/hmu_mult16.v]
// Purpose: registered 16x16 multiplier, signed or unsigned
// Assumes: operands are valid in the cycle of req
// Notes:   one cycle latency, product held until the next request

module hmu_mult16
#(
    parameter W = 16
)
(
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // request
    input  wire             req,
    input  wire             sgn,
    input  wire [W-1:0]     a,
    input  wire [W-1:0]     b,
    // result
    output reg  [2*W-1:0]   prod_q
);

    // =================================================================
    // sign or zero extension then a single product
    wire [W:0]     a_ext;
    wire [W:0]     b_ext;
    wire [2*W+1:0] full;

    assign a_ext = {sgn & a[W-1], a};
    assign b_ext = {sgn & b[W-1], b};
    assign full  = $signed(a_ext) * $signed(b_ext);

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prod_q <= {2*W{1'b0}};
        else if (req)
            prod_q <= full[2*W-1:0];
    end

endmodule // hmu_mult16

// [rtl/hmu_unit.v]
// Purpose: halfword-to-word multiply datapath with illegal fp detection
// Assumes: decode presents one operation per cycle as a one-cycle issue;
//          source words and exception word are stable with issue
// Notes:   results appear two edges after issue, with done_q high one cycle;
//          an fp opcode yields only a trap pulse one edge after issue;
//          the condition field is held between record completions

`include "hmu_regs.vh"

module hmu_unit
#(
    parameter W = 16
)
(
    // clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // issue from decode
    input  wire             issue,
    input  wire             sel_high,
    input  wire             is_signed,
    input  wire             record,
    input  wire [5:0]       primary_opcode,
    input  wire [2*W-1:0]   first_source_register,
    input  wire [2*W-1:0]   second_source_register,
    input  wire [2*W-1:0]   fixed_point_exception_reg,
    // writeback
    output reg              done_q,
    output reg  [2*W-1:0]   result_q,
    output reg              cf_we_q,
    output reg  [3:0]       condition_field_zero_q,
    output reg              xer_we_q,
    // program interrupt
    output reg              prog_int_q,
    output reg  [2*W-1:0]   prog_vector_q
);

    // =================================================================
    // decode and arithmetic helpers
    // opcodes owned by the absent floating-point unit; the set is a local
    // choice, so its bounds live in the header
    function is_fp;
        input [5:0] op;
        begin
            is_fp = (op == `HMU_OPC_FP_A) ||
                    (op == `HMU_OPC_FP_B) ||
                    ((op >= `HMU_OPC_FP_LDMIN) &&
                     (op <= `HMU_OPC_FP_LDMAX));
        end
    endfunction

    // upper or lower halfword of a source word, shared by both operands
    function [W-1:0] half_sel;
        input           hi;
        input [2*W-1:0] word;
        begin
            if (hi)
                half_sel = word[`HMU_HI_MSB:`HMU_HI_LSB];
            else
                half_sel = word[`HMU_LO_MSB:`HMU_LO_LSB];
        end
    endfunction

    // condition bits of a word viewed as signed, even for unsigned forms
    function [3:0] cond_of;
        input [2*W-1:0] val;
        input           so;
        reg             nz;
        begin
            nz                  = |val;
            cond_of             = `HMU_CF_RESET;
            cond_of[`HMU_CF_LT] = val[2*W-1];
            cond_of[`HMU_CF_GT] = ~val[2*W-1] & nz;
            cond_of[`HMU_CF_EQ] = ~nz;
            cond_of[`HMU_CF_SO] = so;
        end
    endfunction

    // =================================================================
    // issue classification
    wire fp_ill;
    wire mul_go;

    // issue is a one-cycle pulse; nothing here stalls or refuses it
    // an fp opcode never reaches the multiplier, so it leaves no result
    assign fp_ill = issue & is_fp(primary_opcode);
    assign mul_go = issue & ~fp_ill;

    // =================================================================
    // halfword select and multiplier
    // bit 0 of the architecture is bit 31 here, so high means [31:16]
    wire [W-1:0]   op_a;
    wire [W-1:0]   op_b;
    wire [2*W-1:0] prod;

    assign op_a = half_sel(sel_high, first_source_register);
    assign op_b = half_sel(sel_high, second_source_register);

    // the product register is the first pipeline stage
    hmu_mult16 #(.W(W)) u_mult
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .req     (mul_go),
        .sgn     (is_signed),
        .a       (op_a),
        .b       (op_b),
        .prod_q  (prod)
    );

    // =================================================================
    // stage 1: side information travels with the product
    reg stage_q;
    reg rec_q;
    reg so_q;

    // marks that the product register took a new value this edge
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stage_q <= 1'b0;
        else
            stage_q <= mul_go;
    end

    // captured only on a real multiply, so an fp issue in between cannot
    // disturb the record flag or overflow copy of the product in flight
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rec_q <= 1'b0;
            so_q  <= 1'b0;
        end
        else if (mul_go)
        begin
            rec_q <= record;
            so_q  <= fixed_point_exception_reg[`HMU_XER_SO];
        end
    end

    // =================================================================
    // stage 2: writeback
    wire [3:0] cf_d;

    // taken off the product register so field and result land together
    assign cf_d = cond_of(prod, so_q);

    // completion pulses last exactly one cycle
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q  <= 1'b0;
            cf_we_q <= 1'b0;
        end
        else
        begin
            done_q  <= stage_q;
            cf_we_q <= stage_q & rec_q;
        end
    end

    // result holds until the next completion, condition field until the next record completion
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            result_q <= {2*W{1'b0}};
        else if (stage_q)
            result_q <= prod;
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            condition_field_zero_q <= `HMU_CF_RESET;
        else if (stage_q & rec_q)
            condition_field_zero_q <= cf_d;
    end

    // no write path to the exception register exists; the strobe is kept
    // so this writeback port looks like that of the other units
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            xer_we_q <= 1'b0;
        else
            xer_we_q <= 1'b0;
    end

    // =================================================================
    // program interrupt for fp attempts
    // the vector stays put after the first trap; it is the only offset
    // this unit ever raises
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_int_q    <= 1'b0;
            prog_vector_q <= {2*W{1'b0}};
        end
        else
        begin
            prog_int_q <= fp_ill;
            if (fp_ill)
                prog_vector_q <= `HMU_VEC_PROGRAM;
        end
    end

endmodule // hmu_unit

// [verification/hmu_dec_model.sv]
// Purpose: decode and register file side of the multiply unit
// Assumes: requests start 1 ns after a rising edge
// Notes:   idle operands are inverted so stale data never looks live
module hmu_dec_model (
    // clock
    input  wire         ref_clk,
    // issue toward the unit
    output logic        issue,
    output logic        sel_high,
    output logic        is_signed,
    output logic        record,
    output logic [5:0]  primary_opcode,
    // operands
    output logic [31:0] first_source_register,
    output logic [31:0] second_source_register,
    output logic [31:0] fixed_point_exception_reg
);
    timeunit 1ns / 1ns;
    // =========================================
    // drivers
    initial
    begin
        {issue, sel_high, is_signed, record, primary_opcode,
         first_source_register, second_source_register,
         fixed_point_exception_reg} = '0;
    end
    task automatic send(logic [9:0] f, logic [31:0] a, b, x);
        @(posedge ref_clk);
        #1;
        {issue, sel_high, is_signed, record, primary_opcode,
         first_source_register, second_source_register,
         fixed_point_exception_reg} = {f, a, b, x};
    endtask
endmodule // hmu_dec_model

// [verification/hmu_unit_chk.sv]
// Purpose: port checks of the halfword multiply unit
// Assumes: one clock, asynchronous active-low reset
// Notes:   reference product is formed from the inputs at issue
module hmu_unit_chk (
    // clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // issue
    input wire        issue,
    input wire        sel_high,
    input wire        is_signed,
    input wire        record,
    input wire [5:0]  primary_opcode,
    input wire [31:0] first_source_register,
    input wire [31:0] second_source_register,
    input wire [31:0] fixed_point_exception_reg,
    // results
    input wire        done_q,
    input wire [31:0] result_q,
    input wire        cf_we_q,
    input wire [3:0]  condition_field_zero_q,
    input wire        xer_we_q,
    input wire        prog_int_q,
    input wire [31:0] prog_vector_q
);
    timeunit 1ns / 1ns;
    wire [31:0] a = first_source_register;
    wire [31:0] b = second_source_register;
    wire [15:0] ha = sel_high ? a[31:16] : a[15:0];
    wire [15:0] hb = sel_high ? b[31:16] : b[15:0];
    wire signed [31:0] ps = $signed(ha) * $signed(hb);
    wire [31:0] prod = is_signed ? ps : ha * hb;
    wire so = fixed_point_exception_reg[31];
    wire [5:0] o = primary_opcode;
    wire fp = o == 6'h3b || o == 6'h3f || o[5:3] == 3'b110;
    wire signed [31:0] rs = result_q;
    wire [3:0] cf = condition_field_zero_q;
    // =========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_mul; issue && !fp; endsequence
    sequence s_fp; issue && fp; endsequence
    sequence s_trap; prog_int_q ##1 (!done_q && !cf_we_q); endsequence
    property p_prod;
        s_mul |-> ##2 result_q == $past(prod, 2);
    endproperty
    property p_vector;
        prog_int_q |-> prog_vector_q == 32'h0000_0700;
    endproperty
    property p_cf_we;
        s_mul |-> ##2 cf_we_q == $past(record, 2);
    endproperty
    property p_cf_sign;
        cf_we_q |-> cf[3:1] == {rs < 0, rs > 0, rs == 0};
    endproperty
    a_mul_done: assert property (s_mul |-> ##2 done_q)
        else $error("multiply late");
    a_mul_prod: assert property (p_prod)
        else $error("bad product");
    a_fp_trap: assert property (s_fp |-> ##1 s_trap)
        else $error("fp not trapped");
    a_fp_vector: assert property (p_vector)
        else $error("bad vector");
    a_xer_quiet: assert property (!xer_we_q)
        else $error("exception reg written");
    a_cf_write: assert property (p_cf_we)
        else $error("bad cf write");
    a_cf_hold: assert property (!cf_we_q |-> $stable(cf))
        else $error("cf moved");
    a_cf_sign: assert property (p_cf_sign)
        else $error("bad cf compare");
    a_cf_so: assert property (cf_we_q |-> cf[0] == $past(so, 2))
        else $error("bad cf overflow");
endmodule // hmu_unit_chk
bind hmu_unit hmu_unit_chk chk_u (.*);

// [verification/test_hmu_unit.sv]
// Purpose: self-checking bench of the halfword multiply unit
// Assumes: issues back to back from a fixed-seed xorshift
// Notes:   integer model results wait in queues until done
module test_hmu_unit;
    timeunit 1ns / 1ns;
    logic ref_clk = 0, rst_n = 0;
    wire issue, sel_high, is_signed, record, done_q, cf_we_q;
    wire xer_we_q, prog_int_q;
    wire [5:0] primary_opcode;
    wire [3:0] condition_field_zero_q;
    wire [31:0] first_source_register, second_source_register;
    wire [31:0] fixed_point_exception_reg, result_q, prog_vector_q;
    int n_mismatch = 0, checks_done = 0, fp_due = 0, ia, ib, r;
    logic [31:0] rng = 32'h2777ed13, a, b, x, q_res[$];
    logic [15:0] ha, hb;
    logic [5:0] op;
    logic [4:0] e, q_cf[$];
    logic [3:0] last_cf = 4'h0;
    hmu_unit dut_u (.*);
    hmu_dec_model dec_u (.*);
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(string nm, logic [31:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] xs;
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // =========================================
    // result monitor
    always @(negedge ref_clk)
    begin
        if (prog_int_q === 1'b1)
        begin
            fp_due--;
            chk("vector", prog_vector_q, 32'h0000_0700);
        end
        if (done_q === 1'b1)
        begin
            e = q_cf.pop_front();
            chk("result", result_q, q_res.pop_front());
            chk("cf_we", cf_we_q, e[4]);
            if (e[4])
                last_cf = e[3:0];
            chk("cf", condition_field_zero_q, last_cf);
            chk("xer_we", xer_we_q, 1'b0);
        end
    end
    initial
    begin
        #300 rst_n = 1;
        for (int i = 0; i < 96; i++)
        begin
            a = (i % 7 == 3) ? 32'h8000_ffff : xs();
            b = (i % 5 == 2) ? 32'hffff_8000 : xs();
            x = xs();
            r = xs();
            op = r[8] & r[7] ? (r[9] ? {3'b110, r[12:10]}
                                     : {3'b111, r[10], 2'b11}) : 6'h04;
            ha = i[0] ? a[31:16] : a[15:0];
            hb = i[0] ? b[31:16] : b[15:0];
            ia = i[1] ? int'($signed(ha)) : int'(ha);
            ib = i[1] ? int'($signed(hb)) : int'(hb);
            r = ia * ib;
            if (op != 6'h04)
                fp_due++;
            else
            begin
                q_res.push_back(r);
                q_cf.push_back({i[2], r < 0, r > 0, r == 0, x[31]});
            end
            dec_u.send({1'b1, i[0], i[1], i[2], op}, a, b, x);
        end
        dec_u.send(10'h004, ~a, ~b, x);
        repeat (4) @(posedge ref_clk);
        chk("fp_left", fp_due, 0);
        chk("mul_left", q_res.size(), 0);
        end_of_test();
    end
    initial
    begin
        #30000;
        n_mismatch++;
        end_of_test();
    end
endmodule // test_hmu_unit
